/* File: logic/mcar_defines.vh */
`ifndef MCAR_DEFINES_VH
`define MCAR_DEFINES_VH
// output layout select codes
`define MCAR_FMT_SPI_PACKED   3'h0
`define MCAR_FMT_SPI_FIXED    3'h1
`define MCAR_FMT_SPI_DISCRETE 3'h2
`define MCAR_FMT_FS_PACKED    3'h3
`define MCAR_FMT_FS_FIXED     3'h4
`define MCAR_FMT_FS_DISCRETE  3'h5
`define MCAR_FMT_MODULATOR    3'h6
// timing counts
`define MCAR_SLEEP_MIN_CLK    2
`define MCAR_NDR_SPI          130
`define MCAR_NDR_FS           129
`define MCAR_CONV_PERIOD      256
`define MCAR_SAMPLE_BITS      24
`define MCAR_MOD_DIV          2
`endif

/* File: logic/mcar_sync2.v */
`timescale 1ns/1ns
// ****************************************
// two-stage synchroniser, vector wide
// ****************************************
module mcar_sync2 #(
  parameter             WIDTH     = 1,
  parameter [WIDTH-1:0] RESET_VAL = {WIDTH{1'b0}}
) (
  input  wire             core_clk,
  input  wire             rst_n,
  input  wire [WIDTH-1:0] asyncIn,
  output reg  [WIDTH-1:0] syncOut
);
  reg [WIDTH-1:0] stage1;

  // first stage is read only by the second; reset to the pins' idle levels
  always @(posedge core_clk) begin
    if (!rst_n) begin
      stage1  <= RESET_VAL;
      syncOut <= RESET_VAL;
    end else begin
      stage1  <= asyncIn;
      syncOut <= stage1;
    end
  end
endmodule

/* File: logic/mcar_channel_power.v */
`timescale 1ns/1ns
`include "mcar_defines.vh"
// ****************************************
// per-channel sleep filter and settle counter
// ****************************************
module mcar_channel_power #(
  parameter CNT_W = 8
) (
  input  wire core_clk,
  input  wire rst_n,
  input  wire sleepSync,
  input  wire convTick,
  input  wire fsMode,
  output reg  awake,
  output reg  ready
);
  reg             lowSeen;
  reg [CNT_W-1:0] settleCnt;
  wire [CNT_W-1:0] settleTarget;
  wire [31:0]      targetFull;

  // counts are plain numbers; keep only the counter's width
  assign targetFull   = fsMode ? `MCAR_NDR_FS : `MCAR_NDR_SPI;
  assign settleTarget = targetFull[CNT_W-1:0];

  // sleep only after two consecutive low samples; glitches ignored
  always @(posedge core_clk) begin
    if (!rst_n) begin
      lowSeen   <= 1'b0;
      awake     <= 1'b1;
      ready     <= 1'b1;
      settleCnt <= {CNT_W{1'b0}};
    end else begin
      lowSeen <= ~sleepSync;
      if (~sleepSync && lowSeen) begin
        awake     <= 1'b0; // [R1] [R23]
        ready     <= 1'b0;
        settleCnt <= {CNT_W{1'b0}};
      end else if (sleepSync && !awake) begin
        awake <= 1'b1; // [R2]
      end else if (awake && !ready && convTick) begin
        // counted on shared tick so the channel lands sample-aligned
        if (settleCnt == settleTarget - 1'b1)
          ready <= 1'b1; // [R4] [R6]
        settleCnt <= settleCnt + 1'b1;
      end
    end
  end
endmodule

/* File: logic/mcar_readout.v */
`timescale 1ns/1ns
`include "mcar_defines.vh"
// Function
// R1 - host holds a channel sleep input low at least 2 master clocks
// R2 - channel resumes when its sleep input returns high
// R3 - all channels asleep: bias off, outputs still driven
// R4 - data valid 129-130 conversions (SPI) or 128-129 (frame-sync) after wake
// R5 - waking or sleeping one channel leaves running channels untouched
// R6 - woken channels stay sample-aligned without realign pulse
// R7 - shared lane: sleeping slot zero when fixed, squeezed out when packed
// R8 - discrete layout: sleeping channel line outputs zeros
// R9 - packed: waking channel joins frame only once its data are ready
// R10 - SPI power-down keyed to ready falling; all asleep forces ready high (code samples sleep inputs every master clock, not at ready falling)
// R11 - three-bit layout select decodes to seven output formats
// R12 - SPI read-only; ready falling marks data; MSB first on falling sclk
// R13 - host keeps SPI below 27MHz master clock
// R14 - outputs change and chain input captured on falling sclk
// R15 - host may run sclk up to master rate, free or stopped
// R16 - host waits one master clock after ready falls before first sclk rise
// R17 - host keeps sclk to master ratio a power of two
// R18 - ready low on new data, high on first following falling sclk
// R19 - unread ready pulses high before next result; data load one clock earlier
// R20 - MSB present once ready low; later bits on successive falling edges
// R21 - chained bits follow after own channel data
// R22 - modulator mode: sclk pin outputs clock, lines carry raw bitstreams
// R23 - sleep input sampled, two consecutive low samples required
module mcar_readout #(
  parameter NCH       = 8,
  parameter BITS      = `MCAR_SAMPLE_BITS,
  parameter CONV_CLKS = `MCAR_CONV_PERIOD
) (
  input  wire            core_clk,
  input  wire            rst_n,
  input  wire [NCH-1:0]  channel_sleep_n,
  input  wire [2:0]      output_layout_sel,
  input  wire            realign_n,
  input  wire            sclkIn,
  input  wire            chain_in,
  input  wire            framePulseIn,
  input  wire [NCH*BITS-1:0] sampleData,
  input  wire [NCH-1:0]  modBits,
  output reg  [NCH-1:0]  conv_out,
  output reg             sample_ready_n,
  output reg             sclkOut,
  output reg             sclkOe,
  output reg             biasEnable,
  output reg  [NCH-1:0]  channelActive
);
  // ****************************************
  // synchronisers and edge detection
  // ****************************************
  wire [NCH-1:0] sleepSync;
  wire [2:0]     selSync;
  wire           sclkSync;
  wire           chainSync;
  wire           frameSync;
  wire           realignSync;
  reg            sclkPrev;
  reg            framePrev;
  wire           sclkFall;
  wire           frameRise;

  // idle levels after reset: channels awake, realign released, sclk low,
  // so no false sleep or false sclk edge follows reset
  mcar_sync2 #(.WIDTH(NCH + 7), .RESET_VAL({{NCH{1'b1}}, 7'h01})) uSync (
    .core_clk (core_clk),
    .rst_n    (rst_n),
    .asyncIn  ({channel_sleep_n, output_layout_sel, sclkIn, chain_in, framePulseIn, realign_n}),
    .syncOut  ({sleepSync, selSync, sclkSync, chainSync, frameSync, realignSync})
  );

  always @(posedge core_clk) begin
    if (!rst_n) begin
      sclkPrev  <= 1'b0;
      framePrev <= 1'b0;
    end else begin
      sclkPrev  <= sclkSync;
      framePrev <= frameSync;
    end
  end

  assign sclkFall  = sclkPrev & ~sclkSync;
  assign frameRise = ~framePrev & frameSync;

  // ****************************************
  // format decode
  // ****************************************
  // protocol decode used by several paths
  function isFrameSync;
    input [2:0] sel;
    begin
      isFrameSync = (sel == `MCAR_FMT_FS_PACKED) || (sel == `MCAR_FMT_FS_FIXED) ||
                    (sel == `MCAR_FMT_FS_DISCRETE);
    end
  endfunction

  wire fsMode     = isFrameSync(selSync);                              // [R11]
  wire modMode    = (selSync == `MCAR_FMT_MODULATOR);                  // [R11]
  wire discMode   = (selSync == `MCAR_FMT_SPI_DISCRETE) || (selSync == `MCAR_FMT_FS_DISCRETE);
  wire packedMode = (selSync == `MCAR_FMT_SPI_PACKED) || (selSync == `MCAR_FMT_FS_PACKED);

  // ****************************************
  // conversion tick
  // ****************************************
  reg [15:0] convCnt;
  wire       convTick = (convCnt == CONV_CLKS - 1);
  wire       loadTick = (convCnt == CONV_CLKS - 2);

  // shared tick keeps every channel aligned; realign restarts it
  always @(posedge core_clk) begin
    if (!rst_n || !realignSync)
      convCnt <= 16'h0000;
    else if (convTick)
      convCnt <= 16'h0000;
    else
      convCnt <= convCnt + 16'h0001;
  end

  // ****************************************
  // channel power
  // ****************************************
  wire [NCH-1:0] awake;
  wire [NCH-1:0] ready;

  genvar g;
  generate
    for (g = 0; g < NCH; g = g + 1) begin : gCh
      // each channel independent, others never disturbed [R5]
      mcar_channel_power uPwr (
        .core_clk  (core_clk),
        .rst_n     (rst_n),
        .sleepSync (sleepSync[g]),
        .convTick  (convTick),
        .fsMode    (fsMode),
        .awake     (awake[g]),
        .ready     (ready[g])
      );
    end
  endgenerate

  wire allAsleep = ~|awake;

  // bias off when all asleep; outputs below keep driving
  always @(posedge core_clk) begin
    if (!rst_n) begin
      biasEnable    <= 1'b1;
      channelActive <= {NCH{1'b0}};
    end else begin
      biasEnable    <= ~allAsleep; // [R3]
      channelActive <= ready;
    end
  end

  // ****************************************
  // frame assembly
  // ****************************************
  localparam FRAME_W = NCH * BITS;
  localparam CNT_W   = 16;

  reg [FRAME_W-1:0] frameWord;
  reg [NCH-1:0]     frameSlots;
  reg [FRAME_W-1:0] shiftReg;
  reg [CNT_W-1:0]   bitCnt;
  reg [CNT_W-1:0]   frameBits;
  reg [BITS-1:0]    discShift [0:NCH-1];
  reg [CNT_W-1:0]   discCnt;
  reg               chainReg;
  wire [31:0]       frameBitsFull;

  // frame length in bits, cut to the bit counter's width
  assign frameBitsFull = countOnes(frameSlots) * BITS;

  // build the shared-lane word: zero slots or squeeze them out
  integer i;
  integer pos;
  always @* begin
    frameWord  = {FRAME_W{1'b0}};
    frameSlots = {NCH{1'b0}};
    pos        = 0;
    for (i = 0; i < NCH; i = i + 1) begin
      if (packedMode) begin
        if (ready[i]) begin
          // packed: later channels move up, waking ones wait [R7] [R9]
          frameWord[FRAME_W-1-pos*BITS -: BITS] = sampleData[FRAME_W-1-i*BITS -: BITS];
          pos = pos + 1;
        end
      end else begin
        // fixed: slot kept, zero when not ready [R7]
        if (ready[i])
          frameWord[FRAME_W-1-i*BITS -: BITS] = sampleData[FRAME_W-1-i*BITS -: BITS];
        pos = pos + 1;
      end
    end
    for (i = 0; i < NCH; i = i + 1)
      frameSlots[i] = (i < pos);
  end

  // ****************************************
  // shifting and ready flag
  // ****************************************
  wire frameStart = fsMode ? frameRise : loadTick;

  always @(posedge core_clk) begin
    if (!rst_n) begin
      shiftReg       <= {FRAME_W{1'b0}};
      bitCnt         <= {CNT_W{1'b0}};
      frameBits      <= {CNT_W{1'b0}};
      discCnt        <= {CNT_W{1'b0}};
      chainReg       <= 1'b0;
      sample_ready_n <= 1'b1;
      for (i = 0; i < NCH; i = i + 1)
        discShift[i] <= {BITS{1'b0}};
    end else if (allAsleep || modMode) begin
      sample_ready_n <= 1'b1; // [R10]
      bitCnt         <= {CNT_W{1'b0}};
    end else if (frameStart) begin
      // new data load one clock before ready falls [R19]
      shiftReg  <= frameWord;
      frameBits <= frameBitsFull[CNT_W-1:0];
      bitCnt    <= {CNT_W{1'b0}};
      discCnt   <= {CNT_W{1'b0}};
      for (i = 0; i < NCH; i = i + 1)
        discShift[i] <= ready[i] ? sampleData[FRAME_W-1-i*BITS -: BITS] : {BITS{1'b0}}; // [R8]
      if (!fsMode)
        sample_ready_n <= 1'b1; // [R19]
    end else begin
      if (!fsMode && convCnt == CONV_CLKS - 1)
        sample_ready_n <= 1'b0; // [R12] [R18]
      if (sclkFall) begin
        if (!fsMode)
          sample_ready_n <= 1'b1; // [R18]
        // shift left, chain bit enters at the bottom [R14] [R21]
        shiftReg <= {shiftReg[FRAME_W-2:0], chainSync};
        chainReg <= chainSync; // [R14]
        bitCnt   <= bitCnt + 16'h0001;
        discCnt  <= discCnt + 16'h0001;
        for (i = 0; i < NCH; i = i + 1)
          discShift[i] <= {discShift[i][BITS-2:0], 1'b0};
      end
    end
  end

  // how many slots the frame carries
  function [CNT_W-1:0] countOnes;
    input [NCH-1:0] v;
    integer k;
    begin
      countOnes = {CNT_W{1'b0}};
      for (k = 0; k < NCH; k = k + 1)
        countOnes = countOnes + {{(CNT_W-1){1'b0}}, v[k]};
    end
  endfunction

  // ****************************************
  // modulator clock divider
  // ****************************************
  reg [7:0] modDiv;
  always @(posedge core_clk) begin
    if (!rst_n) begin
      modDiv  <= 8'h00;
      sclkOut <= 1'b0;
      sclkOe  <= 1'b0;
    end else begin
      sclkOe <= modMode; // [R22]
      if (modDiv == `MCAR_MOD_DIV - 1) begin
        modDiv  <= 8'h00;
        sclkOut <= modMode ? ~sclkOut : 1'b0;
      end else begin
        modDiv <= modDiv + 8'h01;
      end
    end
  end

  // ****************************************
  // output lanes
  // ****************************************
  // msb sits on the line one clock after data load, as ready falls [R20]
  always @(posedge core_clk) begin
    if (!rst_n) begin
      conv_out <= {NCH{1'b0}};
    end else if (modMode) begin
      conv_out <= modBits & awake; // [R22]
    end else if (allAsleep) begin
      conv_out <= {NCH{1'b0}};
    end else if (discMode) begin
      for (i = 0; i < NCH; i = i + 1)
        conv_out[i] <= ready[i] ? discShift[i][BITS-1] : 1'b0; // [R8]
    end else begin
      conv_out    <= {NCH{1'b0}};
      // after own data the chain bits follow, packed frames too [R21]
      conv_out[0] <= (bitCnt >= frameBits) ? chainReg : shiftReg[FRAME_W-1];
    end
  end
endmodule

/* File: test/mcar_readout_props.sv */
`timescale 1ns/1ns
// ****************
// port-level checks
// ****************
module mcar_readout_props #(
  parameter NCH  = 8,
  parameter BITS = 24
) (
  input wire logic                core_clk,
  input wire logic                rst_n,
  input wire logic [NCH-1:0]      channel_sleep_n,
  input wire logic [2:0]          output_layout_sel,
  input wire logic                sclkIn,
  input wire logic [NCH*BITS-1:0] sampleData,
  input wire logic [NCH-1:0]      conv_out,
  input wire logic                sample_ready_n,
  input wire logic                sclkOe,
  input wire logic                biasEnable,
  input wire logic [NCH-1:0]      channelActive
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (!rst_n);
  // repetitions give the input synchronisers time to settle
  a_mod_clk_on: assert property ((output_layout_sel == 3'h6) [*6] |-> sclkOe)
    else $error("modulator clock not enabled");
  a_mod_clk_off: assert property ((output_layout_sel != 3'h6) [*6] |-> !sclkOe)
    else $error("clock pin driven outside modulator layout");
  a_all_asleep: assert property ((channel_sleep_n == '0) [*8] |-> !biasEnable && sample_ready_n)
    else $error("all asleep but bias on or ready low");
  a_bias_back: assert property ((channel_sleep_n != '0) [*8] |-> biasEnable)
    else $error("bias off with a channel awake");
  a_ready_release: assert property ($fell(sclkIn) |-> ##[1:6] sample_ready_n)
    else $error("ready not released after serial clock fall");
  a_ready_pulse: assert property ($fell(sample_ready_n) |-> ##[1:300] sample_ready_n)
    else $error("ready never pulsed high before next result");
  a_msb_first: assert property ((output_layout_sel == 3'h1) [*6] ##0 ($fell(sample_ready_n) && channelActive[0])
    |-> conv_out[0] == sampleData[NCH*BITS-1])
    else $error("msb not present when ready fell");
  a_discrete_zero: assert property ((output_layout_sel == 3'h2 && !channel_sleep_n[0]) [*8] |-> !conv_out[0])
    else $error("sleeping discrete line not zero");
  a_sleep_enter: assert property ((!channel_sleep_n[0]) [*8] |-> !channelActive[0])
    else $error("channel still active after sleep request");
  a_glitch_ignored: assert property (channelActive[0] && channel_sleep_n[0] ##1 !channel_sleep_n[0]
    ##1 channel_sleep_n[0] |-> channelActive[0] [*6])
    else $error("single low sample put channel to sleep");
endmodule
bind mcar_readout mcar_readout_props #(.NCH(NCH), .BITS(BITS)) u_mcar_readout_props (
  .core_clk(core_clk), .rst_n(rst_n), .channel_sleep_n(channel_sleep_n), .output_layout_sel(output_layout_sel),
  .sclkIn(sclkIn), .sampleData(sampleData), .conv_out(conv_out), .sample_ready_n(sample_ready_n),
  .sclkOe(sclkOe), .biasEnable(biasEnable), .channelActive(channelActive));

/* File: test/mcar_host.sv */
`timescale 1ns/1ns
// ****************
// host reader model
// ****************
module mcar_host (
  output logic            sclk,
  input  wire logic [1:0] sdo
);
  logic [31:0] g0;
  logic [31:0] g1;
  // clock parked low between frames
  initial sclk = 1'b0;
  // caller starts just after ready fell, first rise 40 ns later
  // 80 ns period is core rate / 8, a power of two
  // callers keep reads short enough to end before the next load
  // lines sampled just before the fall, before the device reacts
  task automatic readBits(input int n);
    int i;
    g0 = '0;
    g1 = '0;
    for (i = 0; i < n; i++) begin
      #40 sclk = 1'b1;
      #40 g0 = {g0[30:0], sdo[0]};
      g1 = {g1[30:0], sdo[1]};
      sclk = 1'b0;
    end
  endtask
endmodule

/* File: test/tb_mcar_readout.sv */
`timescale 1ns/1ns
// ****************
// readout bench
// ****************
module tb_mcar_readout;
  localparam logic [23:0] W0 = 24'ha5c3f1;
  localparam logic [23:0] W1 = 24'h3c5a96;
  logic       core_clk;
  logic       rst_n;
  logic [1:0] channel_sleep_n;
  logic [2:0] output_layout_sel;
  logic       chain_in;
  logic       sclk;
  logic [1:0] conv_out;
  logic       sample_ready_n;
  logic       sclkOut;
  logic       sclkOe;
  logic       biasEnable;
  logic [1:0] channelActive;
  logic       tmp;
  int         mismatches;
  int         compares;
  time        t0;

  mcar_readout #(.NCH(2)) u_mcar_readout (
    .core_clk(core_clk), .rst_n(rst_n), .channel_sleep_n(channel_sleep_n), .output_layout_sel(output_layout_sel),
    .realign_n(1'b1), .sclkIn(sclk), .chain_in(chain_in), .framePulseIn(1'b0), .sampleData({W0, W1}),
    .modBits(2'b10), .conv_out(conv_out), .sample_ready_n(sample_ready_n), .sclkOut(sclkOut), .sclkOe(sclkOe),
    .biasEnable(biasEnable), .channelActive(channelActive));
  mcar_host u_mcar_host (.sclk(sclk), .sdo(conv_out));

  // free-running master clock; checks here are cycle-based, a real host
  // keeps the SPI layouts at or below the 27MHz master ceiling
  always #5 core_clk = ~core_clk;

  // drive one nanosecond after the edge so no race with the design
  task automatic tick(input int n = 1);
    repeat (n) @(posedge core_clk);
    #1;
  endtask

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      mismatches++;
      $display("unexpected at %0t: saw %h, expected %h", $time, seen, exp);
    end
  endtask

  task automatic results;
    $display("compares %0d mismatches %0d", compares, mismatches);
    if (mismatches == 0 && compares > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  // a fresh fall is needed: a stale unread low says nothing
  task automatic waitRdy;
    int n;
    n = 0;
    while (sample_ready_n !== 1'b1 && n < 600) begin tick(); n++; end
    while (sample_ready_n !== 1'b0 && n < 600) begin tick(); n++; end
    if (n >= 600) begin mismatches++; results(); end
  endtask

  task automatic waitAct(input logic [1:0] m);
    int n;
    n = 0;
    while (channelActive !== m && n < 40000) begin tick(); n++; end
    if (n >= 40000) begin mismatches++; results(); end
  endtask

  task automatic rd(input int n);
    tick(4);
    waitRdy();
    u_mcar_host.readBits(n);
  endtask

  // main sequence
  initial begin
    core_clk = 1'b0;
    rst_n = 1'b0;
    channel_sleep_n = 2'b11;
    output_layout_sel = 3'h1;
    chain_in = 1'b0;
    mismatches = 0;
    compares = 0;
    tick(2);
    rst_n = 1'b1;
    waitAct(2'b11);
    for (int s = 0; s < 7; s++) begin
      output_layout_sel = s[2:0];
      tick(8);
      chk(sclkOe, s == 6);
    end
    chk(conv_out, 2'b10);
    chk(sample_ready_n, 1'b1);
    tmp = sclkOut;
    tick(2);
    chk(sclkOut ^ tmp, 1'b1);
    output_layout_sel = 3'h1;
    rd(24);
    chk(u_mcar_host.g0, W0);
    chk(sample_ready_n, 1'b1);
    // one-cycle low must be ignored, a held low must not
    channel_sleep_n = 2'b10;
    tick();
    channel_sleep_n = 2'b11;
    tick(8);
    chk(channelActive, 2'b11);
    channel_sleep_n = 2'b10;
    chain_in = 1'b1;
    output_layout_sel = 3'h0;
    tick(8);
    chk(channelActive, 2'b10);
    rd(28);
    chk(u_mcar_host.g0, {4'h0, W1, 4'hf});
    output_layout_sel = 3'h1;
    rd(24);
    chk(u_mcar_host.g0, 0);
    output_layout_sel = 3'h2;
    rd(24);
    chk(u_mcar_host.g0, 0);
    chk(u_mcar_host.g1, W1);
    // wake in packed layout: slot joins only once data are ready
    output_layout_sel = 3'h0;
    channel_sleep_n = 2'b11;
    t0 = $time;
    rd(24);
    chk(u_mcar_host.g0, W1);
    waitAct(2'b11);
    chk(($time - t0) / 10 >= 33024 && ($time - t0) / 10 <= 33290, 1'b1);
    rd(24);
    chk(u_mcar_host.g0, W0);
    channel_sleep_n = 2'b00;
    tick(10);
    chk(biasEnable, 1'b0);
    tick(300);
    chk(sample_ready_n, 1'b1);
    channel_sleep_n = 2'b10;
    tick(8);
    chk(biasEnable, 1'b1);
    results();
  end
endmodule
